// *** hw/dmm_pkg.sv ***
package dmm_pkg;

  // special function register addresses
  localparam logic [7:0] AUX_CTRL_ADDR = 8'h8e;
  localparam logic [7:0] AUX_PTR_ADDR = 8'ha2;
  localparam logic [7:0] PTR_LOW_ADDR = 8'h82;
  localparam logic [7:0] PTR_HIGH_ADDR = 8'h83;

  // aux_control_reg field positions
  localparam int SIZE_SEL_BIT = 2;
  localparam int EXT_SEL_BIT = 1;
  localparam int STRETCH_BIT = 5;

  // aux_pointer_boot_ctrl field positions
  localparam int PTR_SEL_BIT = 0;
  localparam int ZERO_BIT = 2;
  localparam int USER_FLAG_BIT = 3;
  localparam int BOOT_EN_BIT = 5;

  // reset values of the stored fields
  localparam logic RST_SIZE_SEL = 1'b0;
  localparam logic RST_EXT_SEL = 1'b0;
  localparam logic RST_STRETCH = 1'b0;
  localparam logic RST_PTR_SEL = 1'b0;
  localparam logic RST_USER_FLAG = 1'b0;
  localparam logic RST_BOOT_EN = 1'b1;
  localparam logic [15:0] RST_POINTER = 16'h0000;

  // memory map figures
  localparam int ERAM_DEPTH = 512;
  localparam logic [15:0] ERAM_SIZE_SMALL = 16'h0100;
  localparam logic [15:0] ERAM_SIZE_LARGE = 16'h0200;
  localparam logic [15:0] BOOT_BASE = 16'h8000;
  localparam int UPPER_HALF_BIT = 7;

  // strobe lengths in clock periods
  localparam logic [4:0] STROBE_SHORT = 5'h06;
  localparam logic [4:0] STROBE_LONG = 5'h1e;

  // cycles from reset release until the security strap is sampled
  localparam logic [1:0] PRESET_WAIT = 2'h3;

  // external bus sequencer states
  typedef enum logic [2:0] {
    XB_IDLE = 3'b001,
    XB_ADDR = 3'b010,
    XB_STRB = 3'b100
  } dmm_xbus_state_type;

endpackage : dmm_pkg

// *** hw/dmm_xbus.sv ***
`timescale 1ns/100ps
module dmm_xbus (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // cycle request
  input wire logic start_i,
  input wire logic use_ptr_i,
  input wire logic write_i,
  input wire logic stretch_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  // port bus pins
  input wire logic [7:0] low_port_in_i,
  output logic [7:0] low_port_out_o,
  output logic low_port_oe_o,
  output logic [7:0] high_port_out_o,
  output logic high_port_oe_o,
  output logic ale_o,
  output logic wr_n_o,
  output logic rd_n_o
);

  dmm_pkg::dmm_xbus_state_type state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [7:0] lo_out_q, lo_out_d, hi_out_q, hi_out_d;
  logic lo_oe_q, lo_oe_d, hi_oe_q, hi_oe_d;
  logic ale_q, ale_d, wr_n_q, wr_n_d, rd_n_q, rd_n_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic [7:0] sync1_q, sync2_q;

  // two-stage synchroniser on the port input
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= low_port_in_i;
      sync2_q <= sync1_q;
    end
  end

  // address phase, then a strobe of 6 or 30 clocks
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    wdata_d = wdata_q;
    lo_out_d = lo_out_q;
    lo_oe_d = lo_oe_q;
    hi_out_d = hi_out_q;
    hi_oe_d = hi_oe_q;
    ale_d = 1'b0;
    wr_n_d = 1'b1;
    rd_n_d = 1'b1;
    done_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      dmm_pkg::XB_IDLE: begin
        lo_oe_d = 1'b0;
        hi_oe_d = 1'b0;
        if (start_i) begin
          state_d = dmm_pkg::XB_ADDR;
          wr_d = write_i;
          wdata_d = wdata_i;
          ale_d = 1'b1;
          lo_out_d = addr_i[7:0];
          lo_oe_d = 1'b1;
          hi_out_d = addr_i[15:8];
          hi_oe_d = use_ptr_i;
          cnt_d = stretch_i ? dmm_pkg::STROBE_LONG - 5'h01
                            : dmm_pkg::STROBE_SHORT - 5'h01;
        end
      end
      dmm_pkg::XB_ADDR: begin
        state_d = dmm_pkg::XB_STRB;
        wr_n_d = ~wr_q;
        rd_n_d = wr_q;
        lo_out_d = wdata_q;
        lo_oe_d = wr_q;
      end
      dmm_pkg::XB_STRB: begin
        if (cnt_q == 5'h00) begin
          state_d = dmm_pkg::XB_IDLE;
          done_d = 1'b1;
          lo_oe_d = 1'b0;
          hi_oe_d = 1'b0;
          if (!wr_q) begin
            rdata_d = sync2_q;
          end
        end else begin
          cnt_d = cnt_q - 5'h01;
          wr_n_d = ~wr_q;
          rd_n_d = wr_q;
        end
      end
      default: begin
        state_d = dmm_pkg::XB_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= dmm_pkg::XB_IDLE;
      cnt_q <= 5'h00;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      lo_out_q <= 8'h00;
      lo_oe_q <= 1'b0;
      hi_out_q <= 8'h00;
      hi_oe_q <= 1'b0;
      ale_q <= 1'b0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      lo_out_q <= lo_out_d;
      lo_oe_q <= lo_oe_d;
      hi_out_q <= hi_out_d;
      hi_oe_q <= hi_oe_d;
      ale_q <= ale_d;
      wr_n_q <= wr_n_d;
      rd_n_q <= rd_n_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign low_port_out_o = lo_out_q;
  assign low_port_oe_o = lo_oe_q;
  assign high_port_out_o = hi_out_q;
  assign high_port_oe_o = hi_oe_q;
  assign ale_o = ale_q;
  assign wr_n_o = wr_n_q;
  assign rd_n_o = rd_n_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // strobe length checks
  chk_strobe_short: assert property (
    (state_q == dmm_pkg::XB_IDLE && start_i && !stretch_i) |=>
      ##1 (!(wr_n_o && rd_n_o))[*6] ##1 (wr_n_o && rd_n_o))
    else $error("short strobe not six clocks");
  chk_strobe_long: assert property (
    (state_q == dmm_pkg::XB_IDLE && start_i && stretch_i) |=>
      ##1 !(wr_n_o && rd_n_o) ##29 !(wr_n_o && rd_n_o)
      ##1 (wr_n_o && rd_n_o))
    else $error("stretched strobe not thirty clocks");

endmodule : dmm_xbus

// *** hw/dmm_top.sv ***
// What this block does
// - 512 bytes expanded RAM at 000h-1FFh
// - lower 128 bytes reachable direct and indirect
// - above 7Fh: direct to SFRs, indirect to upper RAM
// - select bit clear: moves reach expanded RAM
// - register pointer reaches first 256 bytes only
// - pointer moves beyond size run bus cycle
// - size select hides part of expanded RAM
// - size select: 256 bytes clear, 512 set
// - security strap presets external data select
// - register pointer bus move: 8-bit address only
// - pointer bus move: high on port 2, low muxed
// - stack stays in 256-byte internal RAM
// - stretch bit lengthens strobes 6 to 30 clocks
// - two independent 16-bit data pointers
// - aux bit 0 chooses active pointer
// - aux bit 2 always reads zero
// - aux bit 3 plain user flag
// - boot enable maps boot ROM above 7FFFh
// - reset sets boot enable; small variant reserved
// - aux not bit addressable; reset clears select
`timescale 1ns/100ps
module dmm_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // security byte strap
  input wire logic SECURITY_EXT_SEL_I,
  // special function register port
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  output logic SFR_HIT_O,
  // data pointer operations
  input wire logic PTR_LOAD_I,
  input wire logic [15:0] PTR_LOAD_DATA_I,
  input wire logic PTR_INC_I,
  // internal RAM decode
  input wire logic IRAM_REQ_I,
  input wire logic [7:0] IRAM_ADDR_I,
  input wire logic IRAM_INDIRECT_I,
  input wire logic IRAM_STACK_I,
  output logic SEL_LOWER_O,
  output logic SEL_UPPER_O,
  output logic SEL_SFR_O,
  // external move requests
  input wire logic XM_REQ_I,
  input wire logic XM_USE_PTR_I,
  input wire logic XM_WR_I,
  input wire logic [7:0] XM_REG_ADDR_I,
  input wire logic [7:0] XM_WDATA_I,
  output logic XM_DONE_O,
  output logic [7:0] XM_RDATA_O,
  output logic XM_BUSY_O,
  // code fetch mapping
  input wire logic [15:0] FETCH_ADDR_I,
  output logic FETCH_INTERNAL_O,
  // port bus pins
  input wire logic [7:0] LOW_PORT_IN_I,
  output logic [7:0] LOW_PORT_OUT_O,
  output logic LOW_PORT_OE_O,
  output logic [7:0] HIGH_PORT_OUT_O,
  output logic HIGH_PORT_OE_O,
  output logic ALE_O,
  output logic WR_N_O,
  output logic RD_N_O
);

  logic size_sel_q, size_sel_d, ext_sel_q, ext_sel_d;
  logic stretch_q, stretch_d, ptr_sel_q, ptr_sel_d;
  logic flag_q, flag_d, boot_q, boot_d;
  logic [1:0] preset_cnt_q, preset_cnt_d;
  logic strap1_q, strap2_q;
  logic [15:0] ptr_q [0:1];
  logic [15:0] ptr_d [0:1];
  logic [7:0] eram_mem [0:dmm_pkg::ERAM_DEPTH-1];
  logic [7:0] sfr_rdata_q, sfr_rdata_d;
  logic sfr_hit_q, sfr_hit_d;
  logic sel_lo_q, sel_lo_d, sel_up_q, sel_up_d, sel_sfr_q, sel_sfr_d;
  logic done_q, done_d, busy_q, busy_d, fetch_q, fetch_d;
  logic [7:0] xm_rdata_q, xm_rdata_d;
  logic sfr_wr_ctrl, sfr_wr_aux, sfr_wr_lo, sfr_wr_hi;
  logic [15:0] xm_addr, eram_limit, active_ptr;
  logic eram_hit, eram_go, xb_go, xb_done;
  logic [7:0] xb_rdata;
  logic boot_rd;

  assign sfr_wr_ctrl = SFR_WR_I && SFR_ADDR_I == dmm_pkg::AUX_CTRL_ADDR;
  assign sfr_wr_aux = SFR_WR_I && SFR_ADDR_I == dmm_pkg::AUX_PTR_ADDR;
  assign sfr_wr_lo = SFR_WR_I && SFR_ADDR_I == dmm_pkg::PTR_LOW_ADDR;
  assign sfr_wr_hi = SFR_WR_I && SFR_ADDR_I == dmm_pkg::PTR_HIGH_ADDR;
  assign active_ptr = ptr_q[ptr_sel_q];
  assign boot_rd = boot_q && LARGE_VARIANT;

  // strap synchroniser, sampled after reset release
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      strap1_q <= 1'b0;
      strap2_q <= 1'b0;
    end else begin
      strap1_q <= SECURITY_EXT_SEL_I;
      strap2_q <= strap1_q;
    end
  end

  // control fields: byte writes only, no bit access
  always_comb begin
    size_sel_d = size_sel_q;
    ext_sel_d = ext_sel_q;
    stretch_d = stretch_q;
    ptr_sel_d = ptr_sel_q;
    flag_d = flag_q;
    boot_d = boot_q;
    preset_cnt_d = preset_cnt_q;
    if (preset_cnt_q != dmm_pkg::PRESET_WAIT) begin
      preset_cnt_d = preset_cnt_q + 2'h1;
      if (preset_cnt_q + 2'h1 == dmm_pkg::PRESET_WAIT) begin
        ext_sel_d = strap2_q;
      end
    end
    if (sfr_wr_ctrl) begin
      size_sel_d = SFR_WDATA_I[dmm_pkg::SIZE_SEL_BIT];
      ext_sel_d = SFR_WDATA_I[dmm_pkg::EXT_SEL_BIT];
      stretch_d = SFR_WDATA_I[dmm_pkg::STRETCH_BIT];
    end
    if (sfr_wr_aux) begin
      ptr_sel_d = SFR_WDATA_I[dmm_pkg::PTR_SEL_BIT];
      flag_d = SFR_WDATA_I[dmm_pkg::USER_FLAG_BIT];
      boot_d = SFR_WDATA_I[dmm_pkg::BOOT_EN_BIT];
    end
  end

  // control registers
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      size_sel_q <= dmm_pkg::RST_SIZE_SEL;
      ext_sel_q <= dmm_pkg::RST_EXT_SEL;
      stretch_q <= dmm_pkg::RST_STRETCH;
      ptr_sel_q <= dmm_pkg::RST_PTR_SEL;
      flag_q <= dmm_pkg::RST_USER_FLAG;
      boot_q <= dmm_pkg::RST_BOOT_EN;
      preset_cnt_q <= 2'h0;
    end else begin
      size_sel_q <= size_sel_d;
      ext_sel_q <= ext_sel_d;
      stretch_q <= stretch_d;
      ptr_sel_q <= ptr_sel_d;
      flag_q <= flag_d;
      boot_q <= boot_d;
      preset_cnt_q <= preset_cnt_d;
    end
  end

  // two data pointers, only the selected one changes
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_comb begin
      ptr_d[i] = ptr_q[i];
      if (ptr_sel_q == 1'(i)) begin
        if (sfr_wr_lo) begin
          ptr_d[i][7:0] = SFR_WDATA_I;
        end else if (sfr_wr_hi) begin
          ptr_d[i][15:8] = SFR_WDATA_I;
        end else if (PTR_LOAD_I) begin
          ptr_d[i] = PTR_LOAD_DATA_I;
        end else if (PTR_INC_I) begin
          ptr_d[i] = ptr_q[i] + 16'h0001;
        end
      end
    end
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        ptr_q[i] <= dmm_pkg::RST_POINTER;
      end else begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  // register read-back and internal RAM decode
  always_comb begin
    sfr_rdata_d = 8'h00;
    sfr_hit_d = 1'b1;
    case (SFR_ADDR_I)
      dmm_pkg::AUX_CTRL_ADDR: begin
        sfr_rdata_d[dmm_pkg::SIZE_SEL_BIT] = size_sel_q;
        sfr_rdata_d[dmm_pkg::EXT_SEL_BIT] = ext_sel_q;
        sfr_rdata_d[dmm_pkg::STRETCH_BIT] = stretch_q;
      end
      dmm_pkg::AUX_PTR_ADDR: begin
        sfr_rdata_d[dmm_pkg::PTR_SEL_BIT] = ptr_sel_q;
        sfr_rdata_d[dmm_pkg::ZERO_BIT] = 1'b0;
        sfr_rdata_d[dmm_pkg::USER_FLAG_BIT] = flag_q;
        sfr_rdata_d[dmm_pkg::BOOT_EN_BIT] = boot_rd;
      end
      dmm_pkg::PTR_LOW_ADDR: begin
        sfr_rdata_d = active_ptr[7:0];
      end
      dmm_pkg::PTR_HIGH_ADDR: begin
        sfr_rdata_d = active_ptr[15:8];
      end
      default: begin
        sfr_hit_d = 1'b0;
      end
    endcase
    if (!SFR_RD_I) begin
      sfr_hit_d = 1'b0;
      sfr_rdata_d = 8'h00;
    end
    sel_lo_d = IRAM_REQ_I && !IRAM_ADDR_I[dmm_pkg::UPPER_HALF_BIT];
    sel_up_d = IRAM_REQ_I && IRAM_ADDR_I[dmm_pkg::UPPER_HALF_BIT]
               && (IRAM_INDIRECT_I || IRAM_STACK_I);
    sel_sfr_d = IRAM_REQ_I && IRAM_ADDR_I[dmm_pkg::UPPER_HALF_BIT]
                && !IRAM_INDIRECT_I && !IRAM_STACK_I;
    fetch_d = !FETCH_ADDR_I[15] ||
              (FETCH_ADDR_I >= dmm_pkg::BOOT_BASE && boot_rd);
  end

  // external move routing
  assign xm_addr = XM_USE_PTR_I ? active_ptr
                                : {8'h00, XM_REG_ADDR_I};
  assign eram_limit = size_sel_q ? dmm_pkg::ERAM_SIZE_LARGE
                                 : dmm_pkg::ERAM_SIZE_SMALL;
  assign eram_hit = !ext_sel_q && xm_addr < eram_limit;
  assign eram_go = XM_REQ_I && !busy_q && eram_hit;
  assign xb_go = XM_REQ_I && !busy_q && !eram_hit;

  always_comb begin
    done_d = eram_go || xb_done;
    busy_d = busy_q;
    if (xb_go) begin
      busy_d = 1'b1;
    end else if (xb_done) begin
      busy_d = 1'b0;
    end
    xm_rdata_d = xm_rdata_q;
    if (eram_go && !XM_WR_I) begin
      xm_rdata_d = eram_mem[xm_addr[8:0]];
    end else if (xb_done) begin
      xm_rdata_d = xb_rdata;
    end
  end

  // expanded RAM storage, no reset
  always_ff @(posedge SYS_CLK_I) begin
    if (eram_go && XM_WR_I) begin
      eram_mem[xm_addr[8:0]] <= XM_WDATA_I;
    end
  end

  // decode and answer registers
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q <= 1'b0;
      sel_lo_q <= 1'b0;
      sel_up_q <= 1'b0;
      sel_sfr_q <= 1'b0;
      fetch_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      xm_rdata_q <= 8'h00;
    end else begin
      sfr_rdata_q <= sfr_rdata_d;
      sfr_hit_q <= sfr_hit_d;
      sel_lo_q <= sel_lo_d;
      sel_up_q <= sel_up_d;
      sel_sfr_q <= sel_sfr_d;
      fetch_q <= fetch_d;
      done_q <= done_d;
      busy_q <= busy_d;
      xm_rdata_q <= xm_rdata_d;
    end
  end

  // external bus cycle sequencer
  dmm_xbus u_xbus (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .start_i(xb_go),
    .use_ptr_i(XM_USE_PTR_I),
    .write_i(XM_WR_I),
    .stretch_i(stretch_q),
    .addr_i(xm_addr),
    .wdata_i(XM_WDATA_I),
    .done_o(xb_done),
    .rdata_o(xb_rdata),
    .low_port_in_i(LOW_PORT_IN_I),
    .low_port_out_o(LOW_PORT_OUT_O),
    .low_port_oe_o(LOW_PORT_OE_O),
    .high_port_out_o(HIGH_PORT_OUT_O),
    .high_port_oe_o(HIGH_PORT_OE_O),
    .ale_o(ALE_O),
    .wr_n_o(WR_N_O),
    .rd_n_o(RD_N_O)
  );

  assign SFR_RDATA_O = sfr_rdata_q;
  assign SFR_HIT_O = sfr_hit_q;
  assign SEL_LOWER_O = sel_lo_q;
  assign SEL_UPPER_O = sel_up_q;
  assign SEL_SFR_O = sel_sfr_q;
  assign FETCH_INTERNAL_O = fetch_q;
  assign XM_DONE_O = done_q;
  assign XM_RDATA_O = xm_rdata_q;
  assign XM_BUSY_O = busy_q;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  chk_eram_quiet_bus: assert property (
    eram_go |=> XM_DONE_O && !ALE_O && WR_N_O && RD_N_O && !LOW_PORT_OE_O)
    else $error("expanded RAM hit touched the port bus");
  chk_regptr_local: assert property (
    (XM_REQ_I && !busy_q && !ext_sel_q && !XM_USE_PTR_I) |=> XM_DONE_O)
    else $error("register pointer move left expanded RAM");
  chk_size_limit: assert property (
    (XM_REQ_I && !busy_q && !ext_sel_q && XM_USE_PTR_I && !size_sel_q
     && active_ptr >= dmm_pkg::ERAM_SIZE_SMALL) |=> ALE_O && !XM_DONE_O)
    else $error("hidden address did not go to the bus");
  chk_ptr_bus_high: assert property (
    (xb_go && XM_USE_PTR_I) |=> ALE_O && HIGH_PORT_OE_O
      && HIGH_PORT_OUT_O == $past(active_ptr[15:8]))
    else $error("pointer move did not drive high address");
  chk_zero_bit_read: assert property (
    (SFR_RD_I && SFR_ADDR_I == dmm_pkg::AUX_PTR_ADDR) |=>
      SFR_HIT_O && !SFR_RDATA_O[dmm_pkg::ZERO_BIT])
    else $error("aux bit two read as one");
  chk_other_ptr_kept: assert property (
    (sfr_wr_lo && !ptr_sel_q) |=>
      ptr_q[0][7:0] == $past(SFR_WDATA_I) && $stable(ptr_q[1]))
    else $error("unselected pointer changed");
  chk_direct_to_sfr: assert property (
    (IRAM_REQ_I && IRAM_ADDR_I[7] && !IRAM_INDIRECT_I && !IRAM_STACK_I)
      |=> SEL_SFR_O && !SEL_UPPER_O)
    else $error("direct upper access missed the SFRs");
  chk_stack_internal: assert property (
    (IRAM_REQ_I && IRAM_STACK_I) |=> !SEL_SFR_O
      && (SEL_LOWER_O || SEL_UPPER_O))
    else $error("stack access left internal RAM");
  chk_boot_fetch: assert property (
    (FETCH_ADDR_I[15] && !boot_rd) |=> !FETCH_INTERNAL_O)
    else $error("fetch above 7FFFh stayed internal");
  chk_select_next: assert property (
    sfr_wr_aux |=> ptr_sel_q == $past(SFR_WDATA_I[0]))
    else $error("pointer select did not follow the write");

  cov_eram_write: cover property (eram_go && XM_WR_I);
  cov_bus_read: cover property (xb_go && !XM_WR_I);
  cov_stretch_cycle: cover property (xb_go && stretch_q);
  cov_ptr_toggle: cover property (sfr_wr_aux ##1 $changed(ptr_sel_q));

endmodule : dmm_top

// *** bench/dmm_xmem.sv ***
`timescale 1ns/100ps
module dmm_xmem (
  // clock
  input wire logic clk_i,
  // port bus pins from the block
  input wire logic [7:0] low_out_i,
  input wire logic low_oe_i,
  input wire logic [7:0] high_out_i,
  input wire logic high_oe_i,
  input wire logic ale_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  // late data mode
  input wire logic slow_i,
  // resolved port 0 level
  output logic [7:0] low_in_o
);
  logic [7:0] mem [0:1023];
  logic [15:0] addr_q;
  logic [7:0] last_q = 8'h5a;
  int lat_q = 0;
  logic drv;

  // data shows after the access latency; a floating bus toggles
  assign drv = !rd_n_i && (lat_q >= (slow_i ? 20 : 0));
  assign low_in_o = low_oe_i ? low_out_i : drv ? mem[addr_q[9:0]] : ~last_q;

  // address latch, latency count and write capture
  always @(posedge clk_i) begin
    last_q <= low_in_o;
    lat_q <= rd_n_i ? 0 : lat_q + 1;
    if (ale_i) begin
      addr_q <= {high_oe_i ? high_out_i : 8'h00, low_out_i};
    end
    if (!wr_n_i) begin
      mem[addr_q[9:0]] <= low_out_i;
    end
  end
endmodule : dmm_xmem

// *** bench/dmm_top_test.sv ***
`timescale 1ns/100ps
module dmm_top_test;
  localparam logic [7:0] AUX = dmm_pkg::AUX_PTR_ADDR;
  localparam logic [7:0] ACR = dmm_pkg::AUX_CTRL_ADDR;
  localparam logic [7:0] PLO = dmm_pkg::PTR_LOW_ADDR;
  localparam logic [7:0] PHI = dmm_pkg::PTR_HIGH_ADDR;
  logic SYS_CLK_I, RST_I, SECURITY_EXT_SEL_I, SFR_WR_I, SFR_RD_I;
  logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O, IRAM_ADDR_I;
  logic SFR_HIT_O, PTR_LOAD_I, PTR_INC_I, IRAM_REQ_I, IRAM_INDIRECT_I;
  logic [15:0] PTR_LOAD_DATA_I, FETCH_ADDR_I;
  logic IRAM_STACK_I, SEL_LOWER_O, SEL_UPPER_O, SEL_SFR_O, XM_REQ_I;
  logic [7:0] XM_REG_ADDR_I, XM_WDATA_I, XM_RDATA_O, LOW_PORT_IN_I;
  logic XM_USE_PTR_I, XM_WR_I, XM_DONE_O, XM_BUSY_O, FETCH_INTERNAL_O;
  logic [7:0] LOW_PORT_OUT_O, HIGH_PORT_OUT_O;
  logic LOW_PORT_OE_O, HIGH_PORT_OE_O, ALE_O, WR_N_O, RD_N_O, slow;
  int fails = 0;
  int checks = 0;

  // block under test and external memory
  dmm_top #(.LARGE_VARIANT(1'b1)) dmm_top_inst (.SYS_CLK_I, .RST_I,
    .SECURITY_EXT_SEL_I, .SFR_ADDR_I, .SFR_WR_I, .SFR_RD_I, .SFR_WDATA_I,
    .SFR_RDATA_O, .SFR_HIT_O, .PTR_LOAD_I, .PTR_LOAD_DATA_I, .PTR_INC_I,
    .IRAM_REQ_I, .IRAM_ADDR_I, .IRAM_INDIRECT_I, .IRAM_STACK_I,
    .SEL_LOWER_O, .SEL_UPPER_O, .SEL_SFR_O, .XM_REQ_I, .XM_USE_PTR_I,
    .XM_WR_I, .XM_REG_ADDR_I, .XM_WDATA_I, .XM_DONE_O, .XM_RDATA_O,
    .XM_BUSY_O, .FETCH_ADDR_I, .FETCH_INTERNAL_O, .LOW_PORT_IN_I,
    .LOW_PORT_OUT_O, .LOW_PORT_OE_O, .HIGH_PORT_OUT_O, .HIGH_PORT_OE_O,
    .ALE_O, .WR_N_O, .RD_N_O);
  dmm_xmem dmm_xmem_inst (.clk_i(SYS_CLK_I), .low_out_i(LOW_PORT_OUT_O),
    .low_oe_i(LOW_PORT_OE_O), .high_out_i(HIGH_PORT_OUT_O),
    .high_oe_i(HIGH_PORT_OE_O), .ale_i(ALE_O), .wr_n_i(WR_N_O),
    .rd_n_i(RD_N_O), .slow_i(slow), .low_in_o(LOW_PORT_IN_I));

  // clock
  initial begin
    SYS_CLK_I = 1'b0;
    forever #20 SYS_CLK_I = ~SYS_CLK_I;
  end

  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset;
    @(posedge SYS_CLK_I);
    RST_I <= 1'b1;
    repeat (5) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    repeat (3) @(posedge SYS_CLK_I);
  endtask : do_reset

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK_I);
    SFR_ADDR_I <= a;
    SFR_WDATA_I <= d;
    SFR_WR_I <= 1'b1;
    @(posedge SYS_CLK_I);
    SFR_WR_I <= 1'b0;
  endtask : sfr_wr

  // read one register; expectation holds hit flag and data
  task automatic sfr_chk(input logic [7:0] a, input logic [8:0] exp);
    @(posedge SYS_CLK_I);
    SFR_ADDR_I <= a;
    SFR_RD_I <= 1'b1;
    @(posedge SYS_CLK_I);
    SFR_RD_I <= 1'b0;
    #1;
    check({8'h00, SFR_HIT_O, SFR_RDATA_O}, {8'h00, exp});
  endtask : sfr_chk

  task automatic ptr_op(input logic ld, input logic inc, input logic [15:0] d);
    @(posedge SYS_CLK_I);
    PTR_LOAD_DATA_I <= d;
    PTR_LOAD_I <= ld;
    PTR_INC_I <= inc;
    @(posedge SYS_CLK_I);
    PTR_LOAD_I <= 1'b0;
    PTR_INC_I <= 1'b0;
  endtask : ptr_op

  // external move; len 0 means no bus activity at all
  task automatic xchk(input logic p, input logic w, input logic [7:0] ra,
      input logic [7:0] wd, input int len, input logic [16:0] ea,
      input logic [7:0] er);
    int n;
    int t;
    int b;
    logic [16:0] sa;
    n = 0;
    t = 0;
    b = 0;
    sa = 17'h00000;
    @(posedge SYS_CLK_I);
    XM_USE_PTR_I <= p;
    XM_WR_I <= w;
    XM_REG_ADDR_I <= ra;
    XM_WDATA_I <= wd;
    XM_REQ_I <= 1'b1;
    @(posedge SYS_CLK_I);
    XM_REQ_I <= 1'b0;
    #1;
    for (int k = 0; k < 60 && XM_DONE_O !== 1'b1; k++) begin
      if (ALE_O) sa = {HIGH_PORT_OE_O, HIGH_PORT_OUT_O, LOW_PORT_OUT_O};
      if (ALE_O || LOW_PORT_OE_O || HIGH_PORT_OE_O) t++;
      if (!RD_N_O || !WR_N_O) n++;
      if (XM_BUSY_O === 1'b1) b++;
      @(posedge SYS_CLK_I);
      #1;
    end
    check({16'h0000, XM_DONE_O}, 17'h00001);
    check({16'h0000, XM_BUSY_O}, 17'h00000);
    check(17'(b), (len == 0) ? 17'h00000 : 17'(len + 2));
    check(17'(n), 17'(len));
    if (len == 0) check(17'(t), 17'h00000);
    else check(sa, ea);
    if (!w) check({9'h000, XM_RDATA_O}, {9'h000, er});
  endtask : xchk

  task automatic iram(input logic [7:0] a, input logic ind, input logic stk,
      input logic [2:0] exp);
    @(posedge SYS_CLK_I);
    IRAM_ADDR_I <= a;
    IRAM_INDIRECT_I <= ind;
    IRAM_STACK_I <= stk;
    IRAM_REQ_I <= 1'b1;
    @(posedge SYS_CLK_I);
    IRAM_REQ_I <= 1'b0;
    #1;
    check({14'h0000, SEL_LOWER_O, SEL_UPPER_O, SEL_SFR_O}, {14'h0000, exp});
  endtask : iram

  task automatic fchk(input logic [15:0] a, input logic exp);
    @(posedge SYS_CLK_I);
    FETCH_ADDR_I <= a;
    @(posedge SYS_CLK_I);
    #1;
    check({16'h0000, FETCH_INTERNAL_O}, {16'h0000, exp});
  endtask : fchk

  // hang guard
  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end

  // main sequence
  initial begin
    {RST_I, SECURITY_EXT_SEL_I, SFR_WR_I, SFR_RD_I, PTR_LOAD_I} = 5'h10;
    {PTR_INC_I, IRAM_REQ_I, IRAM_INDIRECT_I, IRAM_STACK_I, slow} = 5'h00;
    {XM_REQ_I, XM_USE_PTR_I, XM_WR_I} = 3'h0;
    {SFR_ADDR_I, SFR_WDATA_I, IRAM_ADDR_I} = 24'h000000;
    {XM_REG_ADDR_I, XM_WDATA_I} = 16'h0000;
    {PTR_LOAD_DATA_I, FETCH_ADDR_I} = 32'h00000000;
    do_reset();
    sfr_chk(AUX, 9'h120);
    sfr_chk(ACR, 9'h100);
    sfr_wr(AUX, 8'h2d);
    sfr_chk(AUX, 9'h129);
    sfr_wr(AUX, 8'h2a);
    sfr_chk(AUX, 9'h128);
    sfr_wr(PLO, 8'ha0);
    sfr_wr(PHI, 8'h01);
    sfr_wr(AUX, 8'h29);
    ptr_op(1'b1, 1'b0, 16'h1234);
    sfr_chk(PLO, 9'h134);
    sfr_chk(PHI, 9'h112);
    sfr_wr(AUX, 8'h28);
    sfr_chk(PLO, 9'h1a0);
    ptr_op(1'b0, 1'b1, 16'h0000);
    sfr_chk(PLO, 9'h1a1);
    sfr_wr(ACR, 8'h04);
    xchk(1'b1, 1'b1, 8'h00, 8'h5a, 0, 17'h0, 8'h00);
    xchk(1'b1, 1'b0, 8'h00, 8'h00, 0, 17'h0, 8'h5a);
    sfr_wr(ACR, 8'h00);
    xchk(1'b1, 1'b1, 8'h00, 8'hc3, 6, 17'h101a1, 8'h00);
    xchk(1'b1, 1'b0, 8'h00, 8'h00, 6, 17'h101a1, 8'hc3);
    ptr_op(1'b1, 1'b0, 16'h00a0);
    xchk(1'b0, 1'b1, 8'ha0, 8'h77, 0, 17'h0, 8'h00);
    xchk(1'b1, 1'b0, 8'h00, 8'h00, 0, 17'h0, 8'h77);
    sfr_wr(ACR, 8'h02);
    xchk(1'b0, 1'b1, 8'h40, 8'h99, 6, 17'h00040, 8'h00);
    xchk(1'b0, 1'b0, 8'h40, 8'h00, 6, 17'h00040, 8'h99);
    @(posedge SYS_CLK_I);
    slow <= 1'b1;
    sfr_wr(ACR, 8'h22);
    xchk(1'b0, 1'b0, 8'h40, 8'h00, 30, 17'h00040, 8'h99);
    @(posedge SYS_CLK_I);
    slow <= 1'b0;
    fchk(16'h9000, 1'b1);
    sfr_wr(AUX, 8'h08);
    fchk(16'h9000, 1'b0);
    fchk(16'h1000, 1'b1);
    iram(8'h7f, 1'b0, 1'b0, 3'b100);
    iram(8'h7f, 1'b1, 1'b0, 3'b100);
    iram(8'h80, 1'b0, 1'b0, 3'b001);
    iram(8'h80, 1'b1, 1'b0, 3'b010);
    iram(8'hff, 1'b0, 1'b1, 3'b010);
    @(posedge SYS_CLK_I);
    SECURITY_EXT_SEL_I <= 1'b1;
    do_reset();
    sfr_chk(ACR, 9'h102);
    sfr_chk(AUX, 9'h120);
    report_and_stop();
  end
endmodule : dmm_top_test
